// ===== rtl/mchg_pkg.sv
// Constants and carrier types of the host glue
package mchg_pkg;

   // ----------------------------------------------------------------
   // Host I/O port decode
   // ----------------------------------------------------------------
   localparam int HOST_ADDR_W = 12;          // System address width
   localparam int PORT_SEL_W = 3;            // Low address bits pick one of eight ports
   localparam int PORT_COUNT = 8;            // Ports behind one base
   localparam int BASE_W = HOST_ADDR_W - PORT_SEL_W;
   localparam int IRQ_COUNT = 8;             // Selectable interrupt lines

   // ----------------------------------------------------------------
   // Controller memory space
   // ----------------------------------------------------------------
   localparam int CTL_ADDR_W = 16;           // 64K bytes of data space
   localparam int PROG_ADDR_W = 18;          // 256K bytes of program space
   localparam logic [15:0] CTL_LOOP_ADDR = 16'hD000;   // Loop current status
   localparam logic [15:0] CTL_RXSEL_ADDR = 16'hE400;  // Receive processor select
   localparam logic [15:0] CTL_MODEM_ADDR = 16'hE800;  // Modem control in/out port
   localparam logic [15:0] CTL_MBOX_ADDR = 16'hDC00;   // Eight mailbox bytes
   localparam logic [15:0] CTL_FLAG_ADDR = 16'hDC08;   // Host write flags
   localparam logic [15:0] CTL_TX_ADDR = 16'hDC10;     // Serial transmit byte
   localparam logic [7:0] MODEM_OUT_RESET = 8'h00;     // Modem control out at reset

   // ----------------------------------------------------------------
   // Serial character format
   // ----------------------------------------------------------------
   localparam logic [1:0] LEN_6 = 2'h0;      // Six data bits
   localparam logic [1:0] LEN_7 = 2'h1;      // Seven data bits
   localparam logic [3:0] BITS_6 = 4'h6;
   localparam logic [3:0] BITS_7 = 4'h7;
   localparam logic [3:0] BITS_8 = 4'h8;

   typedef enum logic [1:0] {
      PAR_NONE = 2'b00,
      PAR_EVEN = 2'b01,
      PAR_ODD = 2'b10,
      PAR_MARK = 2'b11
   } mchg_parity_t;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_START = 3'b001,
      TX_DATA = 3'b010,
      TX_PARITY = 3'b011,
      TX_STOP1 = 3'b100,
      TX_STOP2 = 3'b101
   } mchg_tx_state_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic iorN;                            // I/O read strobe
      logic iowN;                            // I/O write strobe
      logic aenN;                            // Address enable
      logic [HOST_ADDR_W-1:0] addr;          // System address
      logic [7:0] data;                      // Host data lines in
      logic externalModeSelect;              // High selects external modem
      logic loopCurrentDetectN;              // Loop current pin
      logic hostReset;                       // Active high host reset
   } mchg_pins_t;

   typedef struct packed {
      logic req;                             // One-cycle access strobe
      logic we;                              // Write when high
      logic [CTL_ADDR_W-1:0] addr;           // Data memory address
      logic [7:0] wdata;                     // Write data
   } mchg_ctl_req_t;

   typedef struct packed {
      logic [1:0] wordLen;                   // 6, 7 or 8 data bits
      mchg_parity_t parity;                  // Parity mode
      logic twoStop;                         // Two stop bits when high
   } mchg_format_t;

   typedef struct packed {
      logic valid;                           // One-cycle received character strobe
      logic [7:0] char;                      // Received data bits, LSB first
      logic parityBit;                       // Received parity bit
   } mchg_rx_char_t;

endpackage : mchg_pkg

// ===== rtl/mchg_host_glue.sv
// Modem controller host glue logic
`timescale 1ns/100ps

// Behaviour
// - Read strobe returns port data
// - Write strobe captures port data
// - Decode only while enable low
// - Address selects the port
// - Data lines two-way internally
// - Only selected IRQ line active
// - Selected IRQ high on request
// - High reset clears all but synchronisers
// - Bank outputs give upper bits
// - Program space 256K bytes
// - Data space 64K bytes
// - Loop level at D000H bit0
// - Receive select at E400H
// - External: data lines output port
// - External: low address input port
// - Active-low flash write enable
// - 6, 7 or 8 data bits
// - Even, odd, mark, none parity
// - One or two stop bits
// - Mode pin low internal, high external
module mchg_host_glue (
   input wire logic core_clk,
   input wire logic resetn,
   input wire mchg_pkg::mchg_pins_t hostPins,
   input wire logic [mchg_pkg::BASE_W-1:0] ioBase,
   input wire logic [2:0] irqSelect,
   input wire logic irqRequest,
   input wire mchg_pkg::mchg_ctl_req_t ctlReq,
   input wire logic ctlProgWrite,
   input wire logic portBit3,
   input wire logic portBit7,
   input wire mchg_pkg::mchg_format_t serialFormat,
   input wire logic txBaudTick,
   input wire mchg_pkg::mchg_rx_char_t rxChar,
   output logic [7:0] hostDataOut,
   output logic hostDataOeN,
   output logic [mchg_pkg::IRQ_COUNT-1:0] irqLines,
   output logic bankSelectLo,
   output logic bankSelectHi,
   output logic rxProcessorSelectN,
   output logic flashWriteEnableN,
   output logic [7:0] ctlRdata,
   output logic ctlRvalid,
   output logic txSerial,
   output logic txBusy,
   output logic rxParityError
);
   import mchg_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      mchg_pins_t sync1;                     // First synchroniser stage
      mchg_pins_t sync2;                     // Second synchroniser stage
      logic iowPrev;                         // Last write strobe level
      logic [PORT_COUNT-1:0][7:0] toHost;    // Bytes the host reads
      logic [PORT_COUNT-1:0][7:0] fromHost;  // Bytes the host wrote
      logic [PORT_COUNT-1:0] hostWrote;      // Sticky host write flags
      logic [7:0] modemOut;                  // Modem control output port
      logic [7:0] hostDataOut;
      logic hostDataOeN;
      logic [IRQ_COUNT-1:0] irqLines;
      logic bankSelectLo;
      logic bankSelectHi;
      logic rxProcessorSelectN;
      logic flashWriteEnableN;
      logic [7:0] ctlRdata;
      logic ctlRvalid;
      mchg_tx_state_t txState;               // Serial transmitter state
      logic [7:0] txShift;                   // Bits still to send
      logic [3:0] txCount;                   // Data bits sent
      logic txParity;                        // Parity bit to send
      logic txSerial;
      logic txBusy;                          // Frame in progress
      logic rxParityError;
   } mchg_state_t;

   mchg_state_t state;                       // Registered state
   mchg_state_t next_state;                  // Next state

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Number of data bits for a length code
   function automatic logic [3:0] charBits(input logic [1:0] len);
      logic [3:0] bits;
      bits = BITS_8;
      if (len == LEN_6) begin
         bits = BITS_6;
      end else if (len == LEN_7) begin
         bits = BITS_7;
      end
      return bits;
   endfunction : charBits

   // Parity bit for a character under a mode
   function automatic logic parityOf(input logic [7:0] ch, input logic [1:0] len,
                                     input mchg_parity_t mode);
      logic [7:0] mask;
      logic odd1;
      mask = 8'hFF >> (4'h8 - charBits(len));
      odd1 = ^(ch & mask);
      unique case (mode)
         PAR_EVEN: parityOf = odd1;
         PAR_ODD: parityOf = ~odd1;
         PAR_MARK: parityOf = 1'b1;
         PAR_NONE: parityOf = 1'b0;
      endcase
   endfunction : parityOf

   // ----------------------------------------------------------------
   // Decoded terms
   // ----------------------------------------------------------------
   logic extMode;                            // External modem operation
   logic hostHit;                            // Address matches our ports
   logic [PORT_SEL_W-1:0] portIdx;           // Selected port
   logic mboxHit;                            // Controller mailbox access
   logic [PORT_SEL_W-1:0] mboxIdx;           // Mailbox index
   logic [PROG_ADDR_W-1:0] progTop;          // Upper program address bits

   always_comb begin
      extMode = state.sync2.externalModeSelect;
      hostHit = !state.sync2.aenN
                && (state.sync2.addr[HOST_ADDR_W-1:PORT_SEL_W] == ioBase);
      portIdx = state.sync2.addr[PORT_SEL_W-1:0];
      mboxHit = (ctlReq.addr[CTL_ADDR_W-1:PORT_SEL_W]
                 == CTL_MBOX_ADDR[CTL_ADDR_W-1:PORT_SEL_W]);
      mboxIdx = ctlReq.addr[PORT_SEL_W-1:0];
      // Upper two bits of the 18-bit program address
      progTop = {~portBit7, ~portBit3, 16'h0000};
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      // Pin synchronisers
      next_state.sync1 = hostPins;
      next_state.sync2 = state.sync1;
      next_state.iowPrev = state.sync2.iowN;

      // Drive the bus on a read, or always in external mode
      next_state.hostDataOeN = 1'b1;
      next_state.hostDataOut = 8'h00;
      if (extMode) begin
         // Data lines carry modem out
         next_state.hostDataOut = state.modemOut;
         next_state.hostDataOeN = 1'b0;
      end else if (hostHit && !state.sync2.iorN) begin
         next_state.hostDataOut = state.toHost[portIdx];
         next_state.hostDataOeN = 1'b0;
      end

      // Host write captured on the strobe's falling edge
      if (!extMode && hostHit && !state.sync2.iowN && state.iowPrev) begin
         next_state.fromHost[portIdx] = state.sync2.data;
      end

      // Only the selected interrupt line may go high
      next_state.irqLines = '0;
      next_state.irqLines[irqSelect] = irqRequest;

      // Banks follow the inverted port bits
      next_state.bankSelectLo = progTop[PROG_ADDR_W-2];
      next_state.bankSelectHi = progTop[PROG_ADDR_W-1];

      // Flash programming strobe
      next_state.flashWriteEnableN = ~ctlProgWrite;

      // Controller memory accesses
      next_state.ctlRvalid = 1'b0;
      next_state.ctlRdata = 8'h00;
      next_state.rxProcessorSelectN = 1'b1;
      if (ctlReq.req) begin
         next_state.ctlRvalid = !ctlReq.we;
         if (ctlReq.addr == CTL_LOOP_ADDR) begin
            // Loop current pin level on bit 0
            next_state.ctlRdata = {7'h00, state.sync2.loopCurrentDetectN};
         end else if (ctlReq.addr == CTL_RXSEL_ADDR) begin
            next_state.rxProcessorSelectN = 1'b0;
         end else if (ctlReq.addr == CTL_MODEM_ADDR) begin
            if (ctlReq.we) begin
               next_state.modemOut = ctlReq.wdata;
            end else begin
               next_state.ctlRdata = state.sync2.addr[7:0];
            end
         end else if (ctlReq.addr == CTL_FLAG_ADDR) begin
            next_state.ctlRdata = state.hostWrote;
         end else if (ctlReq.addr == CTL_TX_ADDR) begin
            // Load only when idle
            if (ctlReq.we && state.txState == TX_IDLE) begin
               next_state.txShift = ctlReq.wdata;
               next_state.txParity = parityOf(ctlReq.wdata, serialFormat.wordLen,
                                              serialFormat.parity);
               next_state.txCount = 4'h0;
               next_state.txState = TX_START;
            end
            next_state.ctlRdata = {7'h00, state.txState != TX_IDLE};
         end else if (mboxHit) begin
            if (ctlReq.we) begin
               next_state.toHost[mboxIdx] = ctlReq.wdata;
            end else begin
               next_state.ctlRdata = state.fromHost[mboxIdx];
               next_state.hostWrote[mboxIdx] = 1'b0;
            end
         end
      end

      // A new write wins over a clear
      if (!extMode && hostHit && !state.sync2.iowN && state.iowPrev) begin
         next_state.hostWrote[portIdx] = 1'b1;
      end

      // Transmitter, one bit per tick
      if (txBaudTick) begin
         unique case (state.txState)
            TX_IDLE: begin
               next_state.txSerial = 1'b1;
            end
            TX_START: begin
               next_state.txSerial = 1'b0;
               next_state.txState = TX_DATA;
            end
            TX_DATA: begin
               next_state.txSerial = state.txShift[0];
               next_state.txShift = {1'b0, state.txShift[7:1]};
               next_state.txCount = state.txCount + 4'h1;
               if (state.txCount + 4'h1 == charBits(serialFormat.wordLen)) begin
                  next_state.txState = (serialFormat.parity == PAR_NONE)
                                       ? TX_STOP1 : TX_PARITY;
               end
            end
            TX_PARITY: begin
               next_state.txSerial = state.txParity;
               next_state.txState = TX_STOP1;
            end
            TX_STOP1: begin
               next_state.txSerial = 1'b1;
               next_state.txState = serialFormat.twoStop ? TX_STOP2 : TX_IDLE;
            end
            TX_STOP2: begin
               next_state.txSerial = 1'b1;
               next_state.txState = TX_IDLE;
            end
            default: begin
               next_state.txState = TX_IDLE;
            end
         endcase
      end

      next_state.txBusy = (next_state.txState != TX_IDLE);
      // Received parity check
      if (rxChar.valid) begin
         next_state.rxParityError = (serialFormat.parity != PAR_NONE)
            && (rxChar.parityBit != parityOf(rxChar.char, serialFormat.wordLen,
                                             serialFormat.parity));
      end

      // Host reset pin clears all else; synchronisers keep running
      if (state.sync2.hostReset) begin
         next_state = reset_state(next_state.sync1, next_state.sync2);
      end
   end

   // Reset image, synchronisers still shifting
   function automatic mchg_state_t reset_state(input mchg_pins_t s1, input mchg_pins_t s2);
      mchg_state_t r;
      r = '0;
      r.sync1 = s1;
      r.sync2 = s2;
      r.iowPrev = 1'b1;
      r.modemOut = MODEM_OUT_RESET;
      r.hostDataOeN = 1'b1;
      r.bankSelectLo = 1'b0;
      r.bankSelectHi = 1'b0;
      r.rxProcessorSelectN = 1'b1;
      r.flashWriteEnableN = 1'b1;
      r.txState = TX_IDLE;
      r.txSerial = 1'b1;
      return r;
   endfunction : reset_state

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Async reset to constants only; pins idle as inactive
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state <= '0;
         state.sync1.iorN <= 1'b1;
         state.sync1.iowN <= 1'b1;
         state.sync1.aenN <= 1'b1;
         state.sync2.iorN <= 1'b1;
         state.sync2.iowN <= 1'b1;
         state.sync2.aenN <= 1'b1;
         state.iowPrev <= 1'b1;
         state.modemOut <= MODEM_OUT_RESET;
         state.hostDataOeN <= 1'b1;
         state.rxProcessorSelectN <= 1'b1;
         state.flashWriteEnableN <= 1'b1;
         state.txState <= TX_IDLE;
         state.txSerial <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Outputs straight from flip-flops
   // ----------------------------------------------------------------
   assign hostDataOut = state.hostDataOut;
   assign hostDataOeN = state.hostDataOeN;
   assign irqLines = state.irqLines;
   assign bankSelectLo = state.bankSelectLo;
   assign bankSelectHi = state.bankSelectHi;
   assign rxProcessorSelectN = state.rxProcessorSelectN;
   assign flashWriteEnableN = state.flashWriteEnableN;
   assign ctlRdata = state.ctlRdata;
   assign ctlRvalid = state.ctlRvalid;
   assign txSerial = state.txSerial;
   assign txBusy = state.txBusy;
   assign rxParityError = state.rxParityError;

endmodule : mchg_host_glue

// ===== test/mchg_host_glue_chk.sv
// Checker of the host glue's port behaviour
`timescale 1ns/100ps
module mchg_host_glue_chk (
   input wire logic core_clk,
   input wire logic resetn,
   input wire mchg_pkg::mchg_pins_t hostPins,
   input wire logic [2:0] irqSelect,
   input wire logic irqRequest,
   input wire mchg_pkg::mchg_ctl_req_t ctlReq,
   input wire logic ctlProgWrite,
   input wire logic portBit3,
   input wire logic portBit7,
   input wire logic txBaudTick,
   input wire logic [7:0] hostDataOut,
   input wire logic hostDataOeN,
   input wire logic [mchg_pkg::IRQ_COUNT-1:0] irqLines,
   input wire logic bankSelectLo,
   input wire logic bankSelectHi,
   input wire logic rxProcessorSelectN,
   input wire logic flashWriteEnableN,
   input wire logic [7:0] ctlRdata,
   input wire logic ctlRvalid,
   input wire logic txSerial,
   input wire logic txBusy
);
   import mchg_pkg::*;
   // ----------------------------------------------------------------
   // Cycles since the host reset pin was last high
   // ----------------------------------------------------------------
   logic [2:0] quiet; // Saturates at 7
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn || hostPins.hostReset) begin
         quiet <= 3'h0;
      end else if (quiet != 3'h7) begin
         quiet <= quiet + 3'h1;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   irq_onehot_a: assert property ($onehot0(irqLines))
      else $error("more than one interrupt line active");
   irq_select_a: assert property (quiet == 3'h7 |->
      irqLines == ($past(irqRequest) ? (8'h01 << $past(irqSelect)) : 8'h00))
      else $error("interrupt line does not follow request");
   bank_map_a: assert property (quiet == 3'h7 |->
      {bankSelectHi, bankSelectLo} == ~$past({portBit7, portBit3}))
      else $error("bank outputs wrong");
   rxsel_cause_a: assert property (!rxProcessorSelectN |->
      $past(ctlReq.req && ctlReq.addr == CTL_RXSEL_ADDR))
      else $error("receive select without access");
   rxsel_pulse_a: assert property (quiet == 3'h7 && ctlReq.req &&
      ctlReq.addr == CTL_RXSEL_ADDR |=> !rxProcessorSelectN ##1 rxProcessorSelectN)
      else $error("receive select pulse wrong");
   loop_read_a: assert property (quiet == 3'h7 && ctlReq.req && !ctlReq.we &&
      ctlReq.addr == CTL_LOOP_ADDR |=> ctlRvalid &&
      ctlRdata == {7'h00, $past(hostPins.loopCurrentDetectN, 3)})
      else $error("loop status read wrong");
   flash_we_a: assert property (quiet == 3'h7 |->
      flashWriteEnableN == !$past(ctlProgWrite))
      else $error("flash write enable wrong");
   host_drive_a: assert property (!hostDataOeN && !hostPins.externalModeSelect &&
      !$past(hostPins.externalModeSelect, 4) |-> !$past(hostPins.iorN, 3) &&
      !$past(hostPins.aenN, 3))
      else $error("data lines driven outside a read");
   tx_hold_a: assert property (quiet == 3'h7 && !txBaudTick && !$past(txBaudTick) |->
      $stable(txSerial))
      else $error("serial line moved without tick");
   tx_idle_a: assert property (!txBusy |-> txSerial)
      else $error("serial line low while idle");
   ext_out_a: assert property (quiet == 3'h7 && hostPins.externalModeSelect &&
      ctlReq.req && ctlReq.we && ctlReq.addr == CTL_MODEM_ADDR |->
      ##2 hostDataOut == $past(ctlReq.wdata, 2) && !hostDataOeN)
      else $error("modem output port wrong");
   // Main scenarios reached
   host_read_c: cover property (!hostDataOeN);
   tx_frame_c: cover property (txBusy ##1 !txBusy);
   irq_raise_c: cover property (|irqLines);
endmodule : mchg_host_glue_chk

// ===== test/mchg_isa_host.sv
// Model of the PC host issuing I/O cycles
`timescale 1ns/100ps
module mchg_isa_host (
   input wire logic core_clk,
   input wire logic [7:0] hostDataOut,
   input wire logic hostDataOeN,
   output logic iorN,
   output logic iowN,
   output logic aenN,
   output logic [11:0] addr,
   output logic [7:0] data
);
   import mchg_pkg::*;
   logic [7:0] wdata; // Last byte put out
   logic drive; // Host owns the data lines
   // Device drive wins; a released bus shows the inverse of the last byte
   assign data = !hostDataOeN ? hostDataOut : (drive ? wdata : ~wdata);
   initial begin
      iorN = 1'b1;
      iowN = 1'b1;
      aenN = 1'b1;
      addr = 12'h000;
      wdata = 8'h00;
      drive = 1'b0;
   end
   // One I/O cycle
   task automatic io(input logic wr, input logic en, input logic [11:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic seen);
      @(negedge core_clk);
      aenN = !en;
      addr = a;
      wdata = d;
      drive = wr;
      @(negedge core_clk);
      iowN = !wr;
      iorN = wr;
      repeat (5) @(negedge core_clk);
      q = data;
      seen = !hostDataOeN;
      iorN = 1'b1;
      iowN = 1'b1;
      aenN = 1'b1;
      drive = 1'b0;
      repeat (4) @(negedge core_clk);
   endtask : io
endmodule : mchg_isa_host

// ===== test/test_mchg_host_glue.sv
// Testbench of the modem controller host glue
`timescale 1ns/100ps
module test_mchg_host_glue;
   import mchg_pkg::*;
   logic core_clk, resetn, iorN, iowN, aenN, mode, loopN, hostRst;
   logic [11:0] hAddr;
   logic [7:0] hData, hostDataOut, ctlRdata;
   mchg_pins_t hostPins;
   logic [BASE_W-1:0] ioBase;
   logic [2:0] irqSelect;
   logic irqRequest, ctlProgWrite, portBit3, portBit7, txBaudTick;
   mchg_ctl_req_t ctlReq;
   mchg_format_t serialFormat;
   mchg_rx_char_t rxChar;
   logic [IRQ_COUNT-1:0] irqLines;
   logic hostDataOeN, bankSelectLo, bankSelectHi, rxProcessorSelectN, flashWriteEnableN;
   logic ctlRvalid, txSerial, txBusy, rxParityError;
   int mismatches, checksDone;
   assign hostPins = {iorN, iowN, aenN, hAddr, hData, mode, loopN, hostRst};
   mchg_host_glue dut (.*);
   mchg_isa_host host (.core_clk(core_clk), .hostDataOut(hostDataOut),
      .hostDataOeN(hostDataOeN), .iorN(iorN), .iowN(iowN), .aenN(aenN), .addr(hAddr),
      .data(hData));
   // ----------------------------------------------------------------
   // Clock, comparison and closing
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checksDone++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   // Controller access; answer read while it stands
   task automatic ctl(input logic we, input logic [15:0] a, input logic [7:0] wd,
      output logic [7:0] rd, output logic sel);
      @(negedge core_clk);
      ctlReq = {1'b1, we, a, wd};
      @(negedge core_clk);
      rd = ctlRdata;
      sel = rxProcessorSelectN;
      check({7'h00, ctlRvalid}, {7'h00, !we});
      ctlReq.req = 1'b0;
   endtask : ctl
   // One baud tick
   task automatic tick;
      @(negedge core_clk);
      txBaudTick = 1'b1;
      @(negedge core_clk);
      txBaudTick = 1'b0;
      repeat (2) @(negedge core_clk);
   endtask : tick
   // Expected parity bit
   function automatic logic par(input mchg_parity_t p, input logic [7:0] d);
      return (p == PAR_EVEN) ? ^d : (p == PAR_ODD) ? ~^d : (p == PAR_MARK);
   endfunction : par
   // Expected frame, first bit in bit 0
   function automatic logic [11:0] frame(input int n, input mchg_parity_t p,
      input logic [7:0] d);
      logic [11:0] f;
      f = 12'hFFF;
      f[0] = 1'b0;
      for (int i = 0; i < n; i++) f[i+1] = d[i];
      if (p != PAR_NONE) f[n+1] = par(p, d);
      return f;
   endfunction : frame
   // Watchdog
   initial begin
      #500000;
      mismatches++;
      finish_test();
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] q, a, b;
      logic s;
      logic [2:0] i;
      logic [11:0] fr;
      int n, len;
      mismatches = 0;
      checksDone = 0;
      void'($urandom(93));
      {resetn, mode, loopN, hostRst, ioBase, irqSelect, irqRequest} = '0;
      {ctlReq, ctlProgWrite, portBit3, portBit7, serialFormat, txBaudTick, rxChar} = '0;
      repeat (5) @(negedge core_clk);
      check({hostDataOeN, txSerial, flashWriteEnableN, rxProcessorSelectN, 4'h0}, 8'hF0);
      resetn = 1'b1;
      for (int k = 0; k < 4; k++) begin // Every bank
         {portBit7, portBit3} = ~2'(k);
         repeat (2) @(negedge core_clk);
         check({6'h00, bankSelectHi, bankSelectLo}, 8'(k));
      end
      for (int k = 0; k < 8; k++) begin // Every interrupt line
         irqSelect = 3'(k);
         irqRequest = 1'($urandom);
         repeat (2) @(negedge core_clk);
         check(irqLines, irqRequest ? 8'h01 << k : 8'h00);
      end
      ctlProgWrite = 1'b1;
      repeat (2) @(negedge core_clk);
      check({7'h00, flashWriteEnableN}, 8'h00);
      ctlProgWrite = 1'b0;
      for (int k = 0; k < 2; k++) begin // Loop status both levels
         loopN = k[0];
         repeat (4) @(negedge core_clk);
         ctl(1'b0, CTL_LOOP_ADDR, 8'h00, q, s);
         check(q, 8'(k));
      end
      ctl(1'b1, CTL_RXSEL_ADDR, 8'h5A, q, s);
      check({7'h00, s}, 8'h00);
      for (int k = 0; k < 4; k++) begin // Mailbox both ways
         ioBase = 9'($urandom);
         i = 3'($urandom);
         a = 8'($urandom);
         b = 8'($urandom);
         ctl(1'b1, CTL_MBOX_ADDR + 16'(i), a, q, s);
         host.io(1'b0, 1'b1, {ioBase, i}, 8'h00, q, s);
         check(q, a);
         check({7'h00, s}, 8'h01);
         host.io(1'b0, 1'b0, {ioBase, i}, 8'h00, q, s);
         check({7'h00, s}, 8'h00);
         host.io(1'b0, 1'b1, {~ioBase, i}, 8'h00, q, s);
         check({7'h00, s}, 8'h00);
         host.io(1'b1, 1'b1, {ioBase, i}, b, q, s);
         host.io(1'b1, 1'b0, {ioBase, i + 3'h1}, ~b, q, s);
         ctl(1'b0, CTL_FLAG_ADDR, 8'h00, q, s);
         check(q, 8'h01 << i);
         ctl(1'b0, CTL_MBOX_ADDR + 16'(i), 8'h00, q, s);
         check(q, b);
         ctl(1'b0, CTL_FLAG_ADDR, 8'h00, q, s);
         check(q, 8'h00);
      end
      for (int k = 0; k < 4; k++) begin // Each length, parity and stop count
         serialFormat = '{wordLen: 2'(k), parity: mchg_parity_t'(k), twoStop: k[0]};
         n = (k == 0) ? 6 : (k == 1) ? 7 : 8;
         a = 8'($urandom) & (8'hFF >> (8 - n));
         fr = frame(n, mchg_parity_t'(k), a);
         len = n + 2 + int'(k != 0) + int'(k[0]);
         ctl(1'b1, CTL_TX_ADDR, a, q, s);
         @(negedge core_clk);
         check({7'h00, txBusy}, 8'h01);
         for (int j = 0; j < len; j++) begin
            if (j == 2) ctl(1'b1, CTL_TX_ADDR, ~a, q, s);
            tick();
            check({7'h00, txSerial}, {7'h00, fr[j]});
         end
         tick();
         check({7'h00, txBusy}, 8'h00);
      end
      for (int k = 0; k < 8; k++) begin // Receive parity check
         serialFormat = '{wordLen: 2'h2, parity: mchg_parity_t'(k % 4), twoStop: 1'b0};
         a = 8'($urandom);
         s = 1'($urandom);
         @(negedge core_clk);
         rxChar = {1'b1, a, par(mchg_parity_t'(k % 4), a) ^ s};
         @(negedge core_clk);
         rxChar.valid = 1'b0;
         repeat (2) @(negedge core_clk);
         check({7'h00, rxParityError}, {7'h00, (k % 4 != 0) & s});
      end
      irqRequest = 1'b1;
      hostRst = 1'b1;
      repeat (5) @(negedge core_clk);
      check(irqLines, 8'h00);
      check({7'h00, hostDataOeN}, 8'h01);
      hostRst = 1'b0;
      mode = 1'b1;
      repeat (8) @(negedge core_clk);
      a = 8'($urandom);
      ctl(1'b1, CTL_MODEM_ADDR, a, q, s);
      @(negedge core_clk);
      check(hostDataOut, a);
      check({7'h00, hostDataOeN}, 8'h00);
      host.io(1'b0, 1'b0, {4'h0, b}, 8'h00, q, s);
      ctl(1'b0, CTL_MODEM_ADDR, 8'h00, q, s);
      check(q, b);
      finish_test();
   end
endmodule : test_mchg_host_glue
bind mchg_host_glue mchg_host_glue_chk chk (.*);
